// *** bench/cpu_clock_ready_reset_gen_tb.sv ***
`timescale 1ns/1ps

module cpu_clock_ready_reset_gen_tb;
  localparam int XH = 5;
  localparam int EH = 4;
  logic sys_clk_i, reset_n_i, sel, clr, res_n, rdy_a, rdy_b, qa_n, qb_n;
  logic xtal, external_freq_in, cpu_clk, pclk, osc, cpu_rst, cpu_rdy;
  logic last_clk = 1'h0, last_pclk, last_rst, last_rdy, last_osc;
  logic [15:0] exp_q[$];
  logic [7:0] hi = 8'h00, per = 8'h00;
  logic [31:0] v;
  logic exp_rdy;
  int err_count = 0, checks = 0, seed = 65717, n, k, h;

  src_model #(.XTAL_HALF(XH), .EXT_HALF(EH)) src_u (.sys_clk_i(sys_clk_i),
    .xtal_osc_o(xtal), .ext_freq_o(external_freq_in));

  cpu_clock_ready_reset_gen dut_u (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .xtal_osc_i(xtal), .external_freq_in_i(external_freq_in),
    .freq_select_i(sel), .divider_clear_sync_i(clr),
    .reset_schmitt_in_n_i(res_n), .bus_ready_in_a_i(rdy_a),
    .bus_ready_in_b_i(rdy_b), .ready_qualifier_a_n_i(qa_n),
    .ready_qualifier_b_n_i(qb_n), .cpu_clk_o(cpu_clk), .periph_clk_o(pclk),
    .oscillator_out_o(osc), .cpu_reset_o(cpu_rst), .cpu_ready_o(cpu_rdy));

  task check(input logic [15:0] seen, input logic [15:0] expv);
    checks++;
    if (seen !== expv) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task complete_run;
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  task falls(input int cnt);
    repeat (cnt) @(negedge cpu_clk);
    @(posedge sys_clk_i);
  endtask : falls

  initial begin
    sys_clk_i = 1'h0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // watcher: high time and period per processor cycle, output timing
  always @(posedge sys_clk_i) begin
    if (last_clk === 1'h1 && cpu_clk === 1'h0) begin
      if (exp_q.size() > 0) begin
        check({hi, per}, exp_q.pop_front());
        check({15'h0000, pclk}, {15'h0000, ~last_pclk});
      end
      hi = 8'h00;
      per = 8'h00;
    end else if (reset_n_i === 1'h1) begin
      check(16'({cpu_rst, cpu_rdy}), 16'({last_rst, last_rdy}));
    end
    if (cpu_clk === 1'h1) hi = hi + 8'h01;
    per = per + 8'h01;
    last_clk = cpu_clk;
    last_pclk = pclk;
    last_rst = cpu_rst;
    last_rdy = cpu_rdy;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'h0;
    sel = 1'h1;
    clr = 1'h0;
    res_n = 1'h1;
    {rdy_a, rdy_b, qa_n, qb_n} = 4'h3;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    for (n = 0; n < 2; n++) begin
      sel <= (n == 0);
      h = (n == 0) ? XH : EH;
      falls(4);
      repeat (2) @(posedge sys_clk_i);
      repeat (3) exp_q.push_back(16'(2 * h * 256 + 6 * h));
      falls(4);
      check(16'(exp_q.size()), 16'h0000);
    end
    // crystal still seen on its output with the external source picked
    k = 0;
    last_osc = osc;
    repeat (4 * XH * 2) begin
      @(posedge sys_clk_i);
      if (osc !== last_osc) k++;
      last_osc = osc;
    end
    check(16'(k), 16'h0008);
    clr <= 1'h1;
    repeat (10) @(posedge sys_clk_i);
    k = 0;
    repeat (40) begin
      @(posedge sys_clk_i);
      if (cpu_clk !== 1'h0 || pclk !== 1'h0) k++;
    end
    check(16'(k), 16'h0000);
    clr <= 1'h0;
    // every qualifier/ready pattern, then random ones
    for (n = 0; n < 24; n++) begin
      v = (n < 16) ? n : $random(seed);
      {rdy_a, rdy_b, qa_n, qb_n} <= v[3:0];
      falls(3);
      exp_rdy = (v[3] & ~v[1]) | (v[2] & ~v[0]);
      check(16'(cpu_rdy), 16'(exp_rdy));
    end
    res_n <= 1'h0;
    falls(2);
    check({15'h0000, cpu_rst}, 16'h0001);
    res_n <= 1'h1;
    falls(2);
    check({15'h0000, cpu_rst}, 16'h0000);
    complete_run();
  end
endmodule : cpu_clock_ready_reset_gen_tb

// *** bench/src_model.sv ***
`timescale 1ns/1ps

module src_model #(
  parameter int XTAL_HALF = 5,
  parameter int EXT_HALF = 4
) (
  input wire logic sys_clk_i,
  output logic xtal_osc_o,
  output logic ext_freq_o
);
  int xtal_cnt = 0;
  int ext_cnt = 0;
  logic xtal_ff = 1'h0;
  logic ext_ff = 1'h0;

  assign xtal_osc_o = xtal_ff;
  assign ext_freq_o = ext_ff;

  // both sources run free, so the idle one still toggles
  // halves kept >= 4 edges so the pin synchronisers see them
  always @(posedge sys_clk_i) begin
    xtal_cnt <= (xtal_cnt == XTAL_HALF - 1) ? 0 : xtal_cnt + 1;
    ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
    if (xtal_cnt == XTAL_HALF - 1) xtal_ff <= ~xtal_ff;
    if (ext_cnt == EXT_HALF - 1) ext_ff <= ~ext_ff;
  end
endmodule : src_model

// *** shared/cpu_clk_cfg.svh ***
`ifndef CPU_CLK_CFG_SVH
`define CPU_CLK_CFG_SVH

// stages of every pin synchroniser
`define CCG_SYNC_STAGES 3
// fewest stages that still give the second/third agreement check
`define CCG_SYNC_MIN 3
// internal divider ratio
`define CCG_DIV_RATIO 3
// output and synchroniser reset levels
`define CCG_LOW 1'h0
`define CCG_HIGH 1'h1
// bit positions of the qualified ready pair
`define CCG_RDY_A 0
`define CCG_RDY_B 1

`endif

// *** shared/cpu_clk_pkg.sv ***
package cpu_clk_pkg;

  // phase of the divide-by-three counter
  typedef enum logic [1:0] {
    PH_HIGH = 2'b00,
    PH_LOW1 = 2'b01,
    PH_LOW2 = 2'b10
  } div_phase_t;

endpackage : cpu_clk_pkg

// *** verilog/cpu_clock_ready_reset_gen.sv ***
// Notes on behaviour
// - divide selected source by three
// - strap low picks external input, high crystal
// - clear input inhibits or aligns the divider
// - clear high holds counters reset
// - processor clock high one period of three
// - peripheral clock at half processor rate
// - peripheral clock has equal high and low
// - reset output changes on processor falling edge
// - sampled inputs taken at next processor edge
// - two ready inputs, each with qualifier
// - active-low qualifier gates its ready input
// - ready inputs synchronised to processor clock
// - ready held past processor hold before clearing
// - crystal kept running on oscillator output
`timescale 1ns/1ps
`include "cpu_clk_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module pin_sync #(
  parameter int STAGES = `CCG_SYNC_STAGES,
  parameter logic RST_VAL = `CCG_LOW
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);

  logic [STAGES-1:0] chain_ff;
  logic level_ff;
  wire agree_w = chain_ff[1] == chain_ff[2];

  generate
    if (STAGES < `CCG_SYNC_MIN) begin : g_bad_stages
      $error("pin_sync needs at least three stages");
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_ff <= {STAGES{RST_VAL}};
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], pin_i};
    end
  end

  // only the second and third stage judge a change, the first stays private
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_ff <= RST_VAL;
    end else if (agree_w) begin
      level_ff <= chain_ff[2];
    end
  end

  assign level_o = level_ff;

endmodule : pin_sync

////////////////////////////////////////////////////////////////////////////////
module cpu_clock_ready_reset_gen #(
  parameter int SYNC_STAGES = `CCG_SYNC_STAGES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic xtal_osc_i,
  input wire logic external_freq_in_i,
  input wire logic freq_select_i,
  input wire logic divider_clear_sync_i,
  input wire logic reset_schmitt_in_n_i,
  input wire logic bus_ready_in_a_i,
  input wire logic bus_ready_in_b_i,
  input wire logic ready_qualifier_a_n_i,
  input wire logic ready_qualifier_b_n_i,
  output logic cpu_clk_o,
  output logic periph_clk_o,
  output logic oscillator_out_o,
  output logic cpu_reset_o,
  output logic cpu_ready_o
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_ff;
  wire rst_n_w = rst_sync_ff[1];

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_ff <= {2{`CCG_LOW}};
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], `CCG_HIGH};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic xtal_s, efi_s, sel_s, clear_s, res_n_s;
  logic rdy_a_s, rdy_b_s, qual_a_n_s, qual_b_n_s;

  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_LOW)) u_xtal (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(xtal_osc_i), .level_o(xtal_s));
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_LOW)) u_efi (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(external_freq_in_i), .level_o(efi_s));
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_HIGH)) u_sel (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(freq_select_i), .level_o(sel_s));
  // clear reads high out of reset, so the divider starts held
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_HIGH)) u_clear (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(divider_clear_sync_i), .level_o(clear_s));
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_LOW)) u_res (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(reset_schmitt_in_n_i), .level_o(res_n_s));
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_LOW)) u_rdy_a (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(bus_ready_in_a_i), .level_o(rdy_a_s));
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_LOW)) u_rdy_b (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(bus_ready_in_b_i), .level_o(rdy_b_s));
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_HIGH)) u_qual_a (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(ready_qualifier_a_n_i), .level_o(qual_a_n_s));
  pin_sync #(.STAGES(SYNC_STAGES), .RST_VAL(`CCG_HIGH)) u_qual_b (
    .clk_i(sys_clk_i), .rst_n_i(rst_n_w),
    .pin_i(ready_qualifier_b_n_i), .level_o(qual_b_n_s));

  //////////////////////////////////////////////////////////////////////////////
  // source selection and edge detect
  logic src_prev_ff;
  wire src_w = sel_s ? xtal_s : efi_s;
  wire src_rise_w = src_w & ~src_prev_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_w) begin
    if (!rst_n_w) begin
      src_prev_ff <= `CCG_LOW;
    end else begin
      src_prev_ff <= src_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // divide-by-three counter
  cpu_clk_pkg::div_phase_t phase_ff, nxt_phase, step_phase;

  always_comb begin
    unique case (phase_ff)
      cpu_clk_pkg::PH_HIGH: step_phase = cpu_clk_pkg::PH_LOW1;
      cpu_clk_pkg::PH_LOW1: step_phase = cpu_clk_pkg::PH_LOW2;
      cpu_clk_pkg::PH_LOW2: step_phase = cpu_clk_pkg::PH_HIGH;
      default: step_phase = cpu_clk_pkg::PH_LOW2;
    endcase
  end

  // parked on the last low phase so the first edge after clear goes high
  assign nxt_phase = clear_s ? cpu_clk_pkg::PH_LOW2 :
                     src_rise_w ? step_phase : phase_ff;

  wire nxt_cpu_clk = ~clear_s & (nxt_phase == cpu_clk_pkg::PH_HIGH);
  logic cpu_clk_ff;
  wire cpu_fall_w = cpu_clk_ff & ~nxt_cpu_clk;

  always_ff @(posedge sys_clk_i or negedge rst_n_w) begin
    if (!rst_n_w) begin
      phase_ff <= cpu_clk_pkg::PH_LOW2;
      cpu_clk_ff <= `CCG_LOW;
    end else begin
      phase_ff <= nxt_phase;
      cpu_clk_ff <= nxt_cpu_clk;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // peripheral clock, reset and ready, moved on the processor fall; clear forces the peripheral clock low at once
  logic periph_ff, reset_ff, ready_ff, osc_ff;
  logic [1:0] rdy_qual_w;

  // a ready line counts only while its qualifier is low
  assign rdy_qual_w[`CCG_RDY_A] = rdy_a_s & ~qual_a_n_s;
  assign rdy_qual_w[`CCG_RDY_B] = rdy_b_s & ~qual_b_n_s;
  wire nxt_periph = clear_s ? `CCG_LOW : periph_ff ^ cpu_fall_w;
  wire nxt_reset = cpu_fall_w ? ~res_n_s : reset_ff;
  // dropping only on a fall keeps ready past the rising-edge hold
  wire nxt_ready = cpu_fall_w ? |rdy_qual_w : ready_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_w) begin
    if (!rst_n_w) begin
      periph_ff <= `CCG_LOW;
      reset_ff <= `CCG_HIGH;
      ready_ff <= `CCG_LOW;
      osc_ff <= `CCG_LOW;
    end else begin
      periph_ff <= nxt_periph;
      reset_ff <= nxt_reset;
      ready_ff <= nxt_ready;
      osc_ff <= xtal_s;
    end
  end

  assign cpu_clk_o = cpu_clk_ff;
  assign periph_clk_o = periph_ff;
  assign cpu_reset_o = reset_ff;
  assign cpu_ready_o = ready_ff;
  assign oscillator_out_o = osc_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_w);

  sequence run_rise_s(cpu_clk_pkg::div_phase_t ph);
    src_rise_w && !clear_s && phase_ff == ph;
  endsequence

  a_div_three_step: assert property (
    run_rise_s(cpu_clk_pkg::PH_HIGH) |=> phase_ff == cpu_clk_pkg::PH_LOW1)
    else $error("divider skipped a phase");

  // previous sample must be the same source, or a strap change looks like
  // an edge; the strap is meant to stay put, so that step is tolerated
  a_source_select: assert property (
    !sel_s && !$past(sel_s) && !clear_s && !(efi_s && !$past(efi_s))
      && phase_ff != 2'b11 |=> $stable(phase_ff))
    else $error("divider moved without an external edge");

  a_clear_holds: assert property (
    clear_s |=> !cpu_clk_o && !periph_clk_o
      && phase_ff == cpu_clk_pkg::PH_LOW2)
    else $error("clear did not hold the divider");

  a_cpu_one_third: assert property (
    run_rise_s(cpu_clk_pkg::PH_LOW2) |=> cpu_clk_o
      ##0 (!src_rise_w throughout (cpu_clk_o [*1])))
    else $error("processor clock high phase wrong");

  a_cpu_low_two: assert property (
    run_rise_s(cpu_clk_pkg::PH_LOW1) |=> !cpu_clk_o)
    else $error("processor clock high too early");

  a_periph_toggle: assert property (
    cpu_fall_w && !clear_s |=> periph_clk_o != $past(periph_clk_o))
    else $error("peripheral clock missed a fall");

  a_periph_steady: assert property (
    !cpu_fall_w && !clear_s |=> $stable(periph_clk_o))
    else $error("peripheral clock moved off a fall");

  a_reset_on_fall: assert property (
    $changed(cpu_reset_o) |-> $past(cpu_fall_w))
    else $error("reset moved away from a fall");

  a_reset_value: assert property (
    cpu_fall_w |=> cpu_reset_o == !$past(res_n_s))
    else $error("reset did not follow its input");

  a_ready_qualify: assert property (
    cpu_fall_w && qual_a_n_s && qual_b_n_s |=> !cpu_ready_o)
    else $error("ready passed an unqualified input");

  a_ready_hold: assert property (
    $fell(cpu_ready_o) |-> $past(cpu_fall_w))
    else $error("ready dropped before the hold");

  a_ready_rise: assert property (
    $rose(cpu_ready_o) |-> $past(cpu_fall_w))
    else $error("ready rose away from a fall");

  // a processor fall that finds one qualified line up
  sequence qual_fall_s(logic rdy, logic qual_n);
    cpu_fall_w && rdy && !qual_n;
  endsequence

  a_ready_pass_a: assert property (
    qual_fall_s(rdy_a_s, qual_a_n_s) |=> cpu_ready_o)
    else $error("qualified ready a was lost");

  a_ready_pass_b: assert property (
    qual_fall_s(rdy_b_s, qual_b_n_s) |=> cpu_ready_o)
    else $error("qualified ready b was lost");

  // high must last until the next source rise
  a_cpu_high_hold: assert property (
    cpu_clk_o && !src_rise_w && !clear_s |=> cpu_clk_o)
    else $error("processor clock high cut short");

  // a fall that clear did not force lands in the first low phase
  a_cpu_fall_phase: assert property (
    $fell(cpu_clk_o) && !$past(clear_s)
      |-> phase_ff == cpu_clk_pkg::PH_LOW1)
    else $error("processor clock fell in wrong phase");

  // parked on the last low phase, so the first rise after clear aligns
  a_clear_park: assert property (
    $fell(clear_s) |-> phase_ff == cpu_clk_pkg::PH_LOW2 && !cpu_clk_o)
    else $error("divider not parked after clear");

  // crystal reaches its output whatever the strap picks
  a_osc_free_run: assert property (
    $changed(xtal_s) |=> $changed(oscillator_out_o))
    else $error("oscillator output stopped");

endmodule : cpu_clock_ready_reset_gen
